// *** dsm_pkg.sv ***
/*
  Package for the data signal modulator: register indices and byte
  addresses, field positions, reset values, selector codes and shared
  types.
  Assumes a 32-bit AXI4-Lite register bus with 16 address bits.
*/
`default_nettype none

package dsm_pkg;

  // Bus widths.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_CONTROL_MAIN = 12'hf4c;
  localparam logic [11:0] IDX_POL_SYNC     = 12'hf4d;
  localparam logic [11:0] IDX_SOURCE_SEL   = 12'hf4e;
  localparam logic [11:0] IDX_LOW_SEL      = 12'hf4f;
  localparam logic [11:0] IDX_HIGH_SEL     = 12'hf50;
  localparam logic [15:0] ADDR_CONTROL_MAIN = {2'b00, IDX_CONTROL_MAIN, 2'b00};
  localparam logic [15:0] ADDR_POL_SYNC     = {2'b00, IDX_POL_SYNC, 2'b00};
  localparam logic [15:0] ADDR_SOURCE_SEL   = {2'b00, IDX_SOURCE_SEL, 2'b00};
  localparam logic [15:0] ADDR_LOW_SEL      = {2'b00, IDX_LOW_SEL, 2'b00};
  localparam logic [15:0] ADDR_HIGH_SEL     = {2'b00, IDX_HIGH_SEL, 2'b00};

  // Field positions in modulator_control_main.
  localparam int POS_ENABLE        = 7;
  localparam int POS_OUTPUT_STATUS = 5;
  localparam int POS_OUTPUT_INVERT = 4;
  localparam int POS_SW_BIT        = 0;
  // Field positions in carrier_polarity_sync_control.
  localparam int POS_HIGH_INVERT   = 5;
  localparam int POS_HIGH_SYNC     = 4;
  localparam int POS_LOW_INVERT    = 1;
  localparam int POS_LOW_SYNC      = 0;

  // Reset values of the stored fields.
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [4:0] RST_SOURCE  = 5'h00;
  localparam logic [3:0] RST_CARRIER = 4'h0;

  // Selector codes that the logic treats specially.
  localparam logic [4:0] SRC_SW_BIT   = 5'h01;
  localparam logic [3:0] CAR_SYS_CLK  = 4'h1;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Number of pin and foreign-clock inputs that pass the synchroniser.
  localparam int N_ASYNC = 5;

  // On-chip peripheral outputs that feed the selectors.
  typedef struct packed {
    logic [7:0] logic_cell;
    logic [1:0] pwm;
    logic [1:0] capture_compare_unit;
    logic [1:0] comparator;
    logic       serial_port1_rx;
    logic       serial_port1_tx;
    logic       sync_serial_port1_sdo;
    logic       sync_serial_port2_sdo;
    logic       serial_port2_rx;
    logic       serial_port2_tx;
  } dsm_src_t;

  // Which carrier the mixer is passing.
  typedef enum logic {CARRIER_LOW, CARRIER_HIGH} dsm_carrier_t;

endpackage

`default_nettype wire

// *** dsm_sync2.sv ***
/*
  Two flip-flop synchroniser for a group of single-bit levels.
  Assumes inputs are asynchronous to aclk and that only the second
  stage is read downstream.
*/
`default_nettype none

module dsm_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Levels in and out.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second, never any logic.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // dsm_sync2

`default_nettype wire

// *** dsm_top.sv ***
/*
  Data signal modulator with AXI4-Lite register slave. A modulation
  source picks between a high and a low carrier, each with optional
  inversion and falling-edge synchronisation, onto one output pin.
  Assumes on-chip sources are on aclk; pins and foreign clocks are
  synchronised here. One write and one read at most are outstanding.
*/
`default_nettype none

module dsm_top (
  // Clock and reset.
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite write address.
  input  wire logic [dsm_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                 awprot,
  input  wire logic                       awvalid,
  output logic                            awready,
  // AXI4-Lite write data.
  input  wire logic [dsm_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  // AXI4-Lite write response.
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  // AXI4-Lite read address.
  input  wire logic [dsm_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                 arprot,
  input  wire logic                       arvalid,
  output logic                            arready,
  // AXI4-Lite read data.
  output logic [dsm_pkg::DATA_W-1:0]      rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  // Pins and foreign clocks, asynchronous to aclk.
  input  wire logic                       high_carrier_pin,
  input  wire logic                       low_carrier_pin,
  input  wire logic                       modulation_pin,
  input  wire logic                       fast_internal_oscillator,
  input  wire logic                       reference_clock_output,
  // On-chip peripheral outputs on aclk.
  input  wire dsm_pkg::dsm_src_t          peripheral_sources,
  // Modulated output pin.
  output logic                            modulated_out
);

  // Stored register fields.
  logic                 enable;
  logic                 output_invert;
  logic                 software_modulation_bit;
  logic                 high_carrier_invert;
  logic                 high_carrier_sync_enable;
  logic                 low_carrier_invert;
  logic                 low_carrier_sync_enable;
  logic [4:0]           modulation_source_selector;
  logic [3:0]           low_carrier_selector;
  logic [3:0]           high_carrier_selector;

  // Bus state.
  logic                 aw_held;
  logic [15:0]          aw_addr_q;
  logic                 w_held;
  logic [7:0]           w_byte_q;
  logic                 w_lane0_q;

  // Mixer state.
  logic [dsm_pkg::N_ASYNC-1:0] async_s;
  logic                 sys_clk_wave;
  logic                 high_prev;
  logic                 low_prev;
  dsm_pkg::dsm_carrier_t carrier;
  dsm_pkg::dsm_carrier_t next_carrier;

  // Pins and foreign clocks cross into aclk here.
  dsm_sync2 #(
    .WIDTH (dsm_pkg::N_ASYNC)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({reference_clock_output, fast_internal_oscillator,
                modulation_pin, low_carrier_pin, high_carrier_pin}),
    .sync_out (async_s)
  );

  // Word-aligned address decode for both channels.
  wire [15:0] wr_addr = {aw_addr_q[15:2], 2'b00};
  wire [15:0] rd_addr = {araddr[15:2], 2'b00};
  wire wr_main = wr_addr == dsm_pkg::ADDR_CONTROL_MAIN;
  wire wr_pol  = wr_addr == dsm_pkg::ADDR_POL_SYNC;
  wire wr_src  = wr_addr == dsm_pkg::ADDR_SOURCE_SEL;
  wire wr_low  = wr_addr == dsm_pkg::ADDR_LOW_SEL;
  wire wr_high = wr_addr == dsm_pkg::ADDR_HIGH_SEL;
  wire wr_hit  = wr_main | wr_pol | wr_src | wr_low | wr_high;
  wire rd_main = rd_addr == dsm_pkg::ADDR_CONTROL_MAIN;
  wire rd_pol  = rd_addr == dsm_pkg::ADDR_POL_SYNC;
  wire rd_src  = rd_addr == dsm_pkg::ADDR_SOURCE_SEL;
  wire rd_low  = rd_addr == dsm_pkg::ADDR_LOW_SEL;
  wire rd_high = rd_addr == dsm_pkg::ADDR_HIGH_SEL;
  wire rd_hit  = rd_main | rd_pol | rd_src | rd_low | rd_high;

  // Handshakes; a write commits once both halves are held.
  assign awready = !aw_held;
  assign wready  = !w_held;
  assign arready = !rvalid;
  wire aw_take  = awvalid & awready;
  wire w_take   = wvalid & wready;
  wire ar_take  = arvalid & arready;
  wire wr_fire  = aw_held & w_held & !bvalid;
  wire wr_apply = wr_fire & w_lane0_q;

  // Read data; the status bit shows the live output pin value.
  // status readback
  wire [7:0] rd_main_v = {enable, 1'b0, modulated_out, output_invert,
                          3'b000, software_modulation_bit};
  wire [7:0] rd_pol_v  = {2'b00, high_carrier_invert,
                          high_carrier_sync_enable, 2'b00,
                          low_carrier_invert, low_carrier_sync_enable};
  wire [7:0] rd_byte   = rd_main ? rd_main_v :
                         rd_pol  ? rd_pol_v :
                         rd_src  ? {3'b000, modulation_source_selector} :
                         rd_low  ? {4'h0, low_carrier_selector} :
                         rd_high ? {4'h0, high_carrier_selector} : 8'h00;

  // Capture each write half independently; either may come first.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held   <= 1'b0;
      aw_addr_q <= 16'h0000;
      w_held    <= 1'b0;
      w_byte_q  <= 8'h00;
      w_lane0_q <= 1'b0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (w_take)
      begin
        w_held    <= 1'b1;
        w_byte_q  <= wdata[7:0];
        w_lane0_q <= wstrb[0];
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= dsm_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? dsm_pkg::RESP_OKAY : dsm_pkg::RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // Read response, registered one cycle after the address is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= dsm_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid <= 1'b1;
      rdata  <= {24'h000000, rd_byte};
      rresp  <= rd_hit ? dsm_pkg::RESP_OKAY : dsm_pkg::RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // Register file; only byte lane 0 holds data, the status bit is
  // read-only. Clearing enable leaves every selection in place.
  // reset defaults
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {enable, output_invert, software_modulation_bit} <= 3'b000;
      {high_carrier_invert, high_carrier_sync_enable} <= 2'b00;
      {low_carrier_invert, low_carrier_sync_enable} <= 2'b00;
      modulation_source_selector <= dsm_pkg::RST_SOURCE;
      low_carrier_selector       <= dsm_pkg::RST_CARRIER;
      high_carrier_selector      <= dsm_pkg::RST_CARRIER;
    end
    else if (wr_apply)
    begin
      if (wr_main)
      begin
        enable                  <= w_byte_q[dsm_pkg::POS_ENABLE];
        output_invert           <= w_byte_q[dsm_pkg::POS_OUTPUT_INVERT];
        software_modulation_bit <= w_byte_q[dsm_pkg::POS_SW_BIT];
      end
      if (wr_pol)
      begin
        high_carrier_invert      <= w_byte_q[dsm_pkg::POS_HIGH_INVERT];
        high_carrier_sync_enable <= w_byte_q[dsm_pkg::POS_HIGH_SYNC];
        low_carrier_invert       <= w_byte_q[dsm_pkg::POS_LOW_INVERT];
        low_carrier_sync_enable  <= w_byte_q[dsm_pkg::POS_LOW_SYNC];
      end
      if (wr_src)
        modulation_source_selector <= w_byte_q[4:0];
      if (wr_low)
        low_carrier_selector <= w_byte_q[3:0];
      if (wr_high)
        high_carrier_selector <= w_byte_q[3:0];
    end
  end

  // The system clock cannot be sampled by itself, so it is stood in
  // for by a wave that toggles on every rising edge, the fastest carrier.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sys_clk_wave <= 1'b0;
    else
      sys_clk_wave <= !sys_clk_wave;
  end

  // Carrier candidates; both selectors share one encoding except code 0, which picks each selector's own carrier pin.
  wire [15:0] carrier_vec = {peripheral_sources.logic_cell,
                             peripheral_sources.pwm,
                             peripheral_sources.capture_compare_unit,
                             async_s[4], async_s[3], sys_clk_wave, 1'b0};
  wire [15:0] high_vec = {carrier_vec[15:1], async_s[0]};
  wire [15:0] low_vec  = {carrier_vec[15:1], async_s[1]};
  wire high_raw = high_vec[high_carrier_selector];
  wire low_raw  = low_vec[low_carrier_selector];
  wire high_adj = high_raw ^ high_carrier_invert;
  wire low_adj  = low_raw ^ low_carrier_invert;

  // Modulation candidates; reserved codes read as low.
  // software bit select
  wire [31:0] mod_vec = {8'h00, peripheral_sources.logic_cell, 2'b00,
                         peripheral_sources.serial_port2_tx,
                         peripheral_sources.serial_port2_rx,
                         peripheral_sources.sync_serial_port2_sdo,
                         peripheral_sources.sync_serial_port1_sdo,
                         peripheral_sources.serial_port1_tx,
                         peripheral_sources.serial_port1_rx,
                         peripheral_sources.comparator,
                         peripheral_sources.pwm,
                         peripheral_sources.capture_compare_unit,
                         software_modulation_bit, async_s[2]};
  wire mod_in = mod_vec[modulation_source_selector];

  // Falling edges of the polarity-adjusted carriers.
  wire high_fall = high_prev & !high_adj;
  wire low_fall  = low_prev & !low_adj;

  // Carrier switching; a synchronised switch waits for the carrier
  // being left to fall, so its last pulse is never truncated.
  always_comb
  begin
    next_carrier = carrier;
    case (carrier)
      dsm_pkg::CARRIER_HIGH:
        if (!mod_in && (!high_carrier_sync_enable || high_fall))
          next_carrier = dsm_pkg::CARRIER_LOW;
      dsm_pkg::CARRIER_LOW:
        if (mod_in && (!low_carrier_sync_enable || low_fall))
          next_carrier = dsm_pkg::CARRIER_HIGH;
      default:
        next_carrier = dsm_pkg::CARRIER_LOW;
    endcase
  end

  // Mix, then apply output polarity; disabled forces the pin low.
  // carrier mixing
  wire mixed = (next_carrier == dsm_pkg::CARRIER_HIGH) ? high_adj : low_adj;
  wire next_mod_out = enable & (mixed ^ output_invert);

  // Mixer state; while disabled the carrier follows the modulation
  // directly so that re-enabling starts on the right carrier.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      carrier       <= dsm_pkg::CARRIER_LOW;
      high_prev     <= 1'b0;
      low_prev      <= 1'b0;
      modulated_out <= 1'b0;
    end
    else
    begin
      carrier       <= enable ? next_carrier :
                       (mod_in ? dsm_pkg::CARRIER_HIGH : dsm_pkg::CARRIER_LOW);
      high_prev     <= high_adj;
      low_prev      <= low_adj;
      modulated_out <= next_mod_out;
    end
  end

  default clocking dsm_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  disabled_pin_low_a: assert property (
    !enable |=> !modulated_out)
    else $error("output pin not low while disabled");

  status_readback_a: assert property (
    ar_take && rd_main |=> rdata[5] == $past(modulated_out))
    else $error("status bit does not show the output");

  high_mix_a: assert property (
    enable && next_carrier == dsm_pkg::CARRIER_HIGH |=>
      modulated_out == $past(high_raw ^ high_carrier_invert ^ output_invert))
    else $error("output does not follow high carrier");

  low_invert_mix_a: assert property (
    enable && next_carrier == dsm_pkg::CARRIER_LOW && low_carrier_invert
      && !output_invert |=> modulated_out == !$past(low_raw))
    else $error("low carrier not inverted on output");

  high_sync_hold_a: assert property (
    enable && carrier == dsm_pkg::CARRIER_HIGH && high_carrier_sync_enable
      && !high_fall |=> carrier == dsm_pkg::CARRIER_HIGH)
    else $error("left high carrier before its falling edge");

  high_nosync_a: assert property (
    enable && carrier == dsm_pkg::CARRIER_HIGH && !mod_in
      && !high_carrier_sync_enable |=> carrier == dsm_pkg::CARRIER_LOW)
    else $error("unsynchronised switch to low carrier delayed");

  low_sync_hold_a: assert property (
    enable && carrier == dsm_pkg::CARRIER_LOW && low_carrier_sync_enable
      && !low_fall |=> carrier == dsm_pkg::CARRIER_LOW)
    else $error("left low carrier before its falling edge");

  sw_bit_drive_a: assert property (
    enable && modulation_source_selector == dsm_pkg::SRC_SW_BIT
      && !high_carrier_sync_enable && !low_carrier_sync_enable
      |=> (carrier == dsm_pkg::CARRIER_HIGH) == $past(software_modulation_bit))
    else $error("software bit does not steer the carrier");

  reserved_source_a: assert property (
    modulation_source_selector[4:3] == 2'b11 |-> !mod_in)
    else $error("reserved modulation code not read as low");

  sys_clk_carrier_a: assert property (
    high_carrier_selector == dsm_pkg::CAR_SYS_CLK ##1
      high_carrier_selector == dsm_pkg::CAR_SYS_CLK |-> $changed(high_raw))
    else $error("system clock carrier does not toggle");

  // All three selectors back at their reset codes.
  wire carrier_sel_zero = high_carrier_selector == dsm_pkg::RST_CARRIER &&
                          low_carrier_selector == dsm_pkg::RST_CARRIER &&
                          modulation_source_selector == dsm_pkg::RST_SOURCE;

  reset_defaults_a: assert property (
    !$past(aresetn) |-> !enable && !modulated_out && carrier_sel_zero)
    else $error("registers not at defaults after reset");

endmodule // dsm_top

`default_nettype wire

// *** dsm_partner.sv ***
/*
  Model of the on-chip peripherals and pins that feed the modulator.
  Assumes the bench sets the wanted levels; they appear one edge later.
*/
`default_nettype none

module dsm_partner (
  // Clock.
  input  wire logic               aclk,
  // Levels wanted by the bench.
  input  wire dsm_pkg::dsm_src_t  src_in,
  input  wire logic [4:0]         pins_in,
  // Levels seen by the modulator.
  output var dsm_pkg::dsm_src_t   src_out,
  output logic      [4:0]         pins_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Peripheral outputs are registered, as real ones leave a flop.
  always_ff @(posedge aclk)
  begin
    src_out  <= src_in;
    pins_out <= pins_in;
  end
endmodule // dsm_partner

`default_nettype wire

// *** test_data_signal_modulator.sv ***
/*
  Self-checking bench for the modulator: register bus, mixing, sync.
  Assumes dsm_top and dsm_partner; sources stay static while checked.
*/
`default_nettype none

module test_data_signal_modulator;
  timeunit 1ns;
  timeprecision 1ps;

  logic              aclk, aresetn, awvalid, awready, wvalid, wready;
  logic              bvalid, bready, arvalid, arready, rvalid, rready;
  logic              modulated_out, e;
  logic [15:0]       awaddr, araddr;
  logic [31:0]       wdata, rdata, rdv, tmp;
  logic [3:0]        wstrb, hc, lcs;
  logic [2:0]        awprot, arprot;
  logic [1:0]        bresp, rresp, rsp;
  logic [4:0]        pins_drv, pins_dut, mc;
  logic [7:0]        pol, ctl;
  dsm_pkg::dsm_src_t src_drv, src_dut;
  integer            seed = 32'h35c3;
  int                miscompares = 0;
  int                checks_done = 0;
  logic [15:0]       reg_addr [5] = '{dsm_pkg::ADDR_CONTROL_MAIN,
    dsm_pkg::ADDR_POL_SYNC, dsm_pkg::ADDR_SOURCE_SEL,
    dsm_pkg::ADDR_LOW_SEL, dsm_pkg::ADDR_HIGH_SEL};

  dsm_partner dsm_partner_inst (.aclk(aclk), .src_in(src_drv),
    .pins_in(pins_drv), .src_out(src_dut), .pins_out(pins_dut));

  dsm_top dsm_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .high_carrier_pin(pins_dut[0]),
    .low_carrier_pin(pins_dut[1]), .modulation_pin(pins_dut[2]),
    .fast_internal_oscillator(pins_dut[3]),
    .reference_clock_output(pins_dut[4]),
    .peripheral_sources(src_dut), .modulated_out(modulated_out));

  // Free-running system clock, 40 ns period.
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    checks_done++;
    if (g !== x)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask

  // Write: address and data offered together, each dropped when taken.
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", {30'h0, dsm_pkg::RESP_OKAY}, {30'h0, r});
  endtask

  task automatic check_out(input logic x);
    repeat (8) @(posedge aclk);
    chk("modulated_out", {31'h0, x}, {31'h0, modulated_out});
  endtask

  // Modulation input that the selector code should pick.
  function automatic logic mod_in(input logic [4:0] c);
    case (c)
      5'h00: return pins_drv[2];
      5'h01: return ctl[0];
      5'h02, 5'h03: return src_drv.capture_compare_unit[c[0]];
      5'h04, 5'h05: return src_drv.pwm[c[0]];
      5'h06, 5'h07: return src_drv.comparator[c[0]];
      5'h08: return src_drv.serial_port1_rx;
      5'h09: return src_drv.serial_port1_tx;
      5'h0a: return src_drv.sync_serial_port1_sdo;
      5'h0b: return src_drv.sync_serial_port2_sdo;
      5'h0c: return src_drv.serial_port2_rx;
      5'h0d: return src_drv.serial_port2_tx;
      default: return c[4:3] == 2'b10 && src_drv.logic_cell[c[2:0]];
    endcase
  endfunction

  // Carrier picked by a four-bit code; code 1 is never used here.
  function automatic logic car_in(input logic [3:0] c, input logic p);
    case (c)
      4'h0: return p;
      4'h2: return pins_drv[3];
      4'h3: return pins_drv[4];
      4'h4, 4'h5: return src_drv.capture_compare_unit[c[0]];
      4'h6, 4'h7: return src_drv.pwm[c[0]];
      default: return src_drv.logic_cell[c[2:0]];
    endcase
  endfunction

  task automatic check_defaults;
    foreach (reg_addr[i])
    begin
      rd(reg_addr[i], rdv, rsp);
      chk("register default", 32'h0, rdv);
    end
    chk("modulated_out", 32'h0, {31'h0, modulated_out});
    $display("test defaults done");
  endtask

  // Switch away from a carrier that must first fall; hi picks which.
  task automatic sync_case(input logic hi);
    wreg(dsm_pkg::ADDR_POL_SYNC, 8'h00);
    wreg(dsm_pkg::ADDR_HIGH_SEL, 8'h08);
    wreg(dsm_pkg::ADDR_LOW_SEL, 8'h09);
    wreg(dsm_pkg::ADDR_SOURCE_SEL, {3'b000, dsm_pkg::SRC_SW_BIT});
    src_drv <= {6'h00, hi, !hi, 12'h000};
    wreg(dsm_pkg::ADDR_CONTROL_MAIN, {7'h40, hi});
    check_out(1'b0);
    wreg(dsm_pkg::ADDR_POL_SYNC, hi ? 8'h10 : 8'h01);
    wreg(dsm_pkg::ADDR_CONTROL_MAIN, {7'h40, !hi});
    check_out(1'b0);
    src_drv <= {6'h00, !hi, hi, 12'h000};
    check_out(1'b1);
    src_drv <= {6'h00, hi, !hi, 12'h000};
    check_out(1'b1);
    $display("test sync %0d done", hi);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // A hung handshake ends the run here.
  initial
  begin
    repeat (30000) @(posedge aclk);
    miscompares++;
    final_report;
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 64'h0;
    {awprot, arprot} = 6'h00;
    wstrb = 4'h1;
    pins_drv = 5'h00;
    src_drv = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    check_defaults;
    // Every source code and every carrier code but 1, random levels and polarities.
    for (int k = 0; k < 64; k++)
    begin
      tmp = $random(seed);
      src_drv <= tmp[19:0];
      tmp = $random(seed);
      pins_drv <= tmp[4:0];
      mc = 5'(k);
      hc = (k[3:0] == 4'h1) ? 4'h0 : k[3:0];
      lcs = (k[5:2] == 4'h1) ? 4'h0 : k[5:2];
      pol = {2'b00, tmp[5], 3'b000, tmp[6], 1'b0};
      ctl = {1'b1, 2'b00, tmp[7], 3'b000, tmp[8]};
      wreg(dsm_pkg::ADDR_SOURCE_SEL, {3'b000, mc});
      wreg(dsm_pkg::ADDR_HIGH_SEL, {4'h0, hc});
      wreg(dsm_pkg::ADDR_LOW_SEL, {4'h0, lcs});
      wreg(dsm_pkg::ADDR_POL_SYNC, pol);
      wreg(dsm_pkg::ADDR_CONTROL_MAIN, ctl);
      e = ctl[4] ^ (mod_in(mc) ? car_in(hc, pins_drv[0]) ^ pol[5]
                               : car_in(lcs, pins_drv[1]) ^ pol[1]);
      check_out(e);
      rd(dsm_pkg::ADDR_CONTROL_MAIN, rdv, rsp);
      chk("control_main", {24'h0, ctl | {2'b00, e, 5'h00}}, rdv);
    end
    $display("test mixing done");
    sync_case(1'b1);
    sync_case(1'b0);
    // Disabled with inversion set: pin low, selections kept.
    wreg(dsm_pkg::ADDR_CONTROL_MAIN, 8'h10);
    check_out(1'b0);
    rd(dsm_pkg::ADDR_SOURCE_SEL, rdv, rsp);
    chk("source_sel", 32'h1, rdv);
    wr(16'h0000, 8'hff, rsp);
    chk("unmapped bresp", {30'h0, dsm_pkg::RESP_SLVERR}, {30'h0, rsp});
    rd(16'h0000, rdv, rsp);
    chk("unmapped rresp", {30'h0, dsm_pkg::RESP_SLVERR}, {30'h0, rsp});
    $display("test disable done");
    // Re-enable on the high carrier, which stands high: pin follows it.
    wreg(dsm_pkg::ADDR_POL_SYNC, 8'h00);
    wreg(dsm_pkg::ADDR_CONTROL_MAIN, 8'h81);
    check_out(1'b1);
    // The system clock carrier must change level on every sample.
    wreg(dsm_pkg::ADDR_HIGH_SEL, {4'h0, dsm_pkg::CAR_SYS_CLK});
    repeat (4) @(posedge aclk);
    e = modulated_out;
    @(posedge aclk);
    chk("system clock carrier", {31'h0, !e}, {31'h0, modulated_out});
    $display("test resume and system clock done");
    wreg(dsm_pkg::ADDR_CONTROL_MAIN, 8'h91);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    check_defaults;
    final_report;
  end
endmodule // test_data_signal_modulator

`default_nettype wire
